// *** verilog/ssimk_top.sv ***
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ssimk_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_holding_free,
    input wire logic tx_fully_drained,
    input wire logic tx_transfer_count_done,
    input wire logic tx_buffers_exhausted,
    input wire logic rx_word_available,
    input wire logic rx_overwrite_error,
    input wire logic rx_transfer_count_done,
    input wire logic rx_buffers_filled,
    input wire logic compare_zero_hit,
    input wire logic compare_one_hit,
    input wire logic tx_frame_sync_seen,
    input wire logic rx_frame_sync_seen,
    output logic irq
);
    localparam int N = ssimk_pkg::NUM_SOURCES;

    ssimk_pkg::ssimk_apb_req_s req;
    logic [N-1:0] src;
    logic [N-1:0] force_q;
    logic [N-1:0] mask;
    logic [N-1:0] flags;
    logic access;
    logic wr_set;
    logic wr_clr;
    logic wr_force;
    logic rd_status;
    logic known;
    ssimk_pkg::ssimk_word_s rword;
    logic [31:0] prdata_q;
    logic irq_q;

    // Bundle the bus request
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign access = req.sel && req.enable;

    // Source vector in documented bit order; software can force a one-shot event
    always_comb
    begin
        src = '0;
        src[ssimk_pkg::BIT_TX_HOLDING_FREE] = tx_holding_free;
        src[ssimk_pkg::BIT_TX_FULLY_DRAINED] = tx_fully_drained;
        src[ssimk_pkg::BIT_TX_TRANSFER_COUNT_DONE] = tx_transfer_count_done;
        src[ssimk_pkg::BIT_TX_BUFFERS_EXHAUSTED] = tx_buffers_exhausted;
        src[ssimk_pkg::BIT_RX_WORD_AVAILABLE] = rx_word_available;
        src[ssimk_pkg::BIT_RX_OVERWRITE_ERROR] =
            rx_overwrite_error | force_q[ssimk_pkg::BIT_RX_OVERWRITE_ERROR];
        src[ssimk_pkg::BIT_RX_TRANSFER_COUNT_DONE] = rx_transfer_count_done;
        src[ssimk_pkg::BIT_RX_BUFFERS_FILLED] = rx_buffers_filled;
        src[ssimk_pkg::BIT_COMPARE_ZERO_HIT] =
            compare_zero_hit | force_q[ssimk_pkg::BIT_COMPARE_ZERO_HIT];
        src[ssimk_pkg::BIT_COMPARE_ONE_HIT] =
            compare_one_hit | force_q[ssimk_pkg::BIT_COMPARE_ONE_HIT];
        src[ssimk_pkg::BIT_TX_FRAME_SYNC_SEEN] =
            tx_frame_sync_seen | force_q[ssimk_pkg::BIT_TX_FRAME_SYNC_SEEN];
        src[ssimk_pkg::BIT_RX_FRAME_SYNC_SEEN] =
            rx_frame_sync_seen | force_q[ssimk_pkg::BIT_RX_FRAME_SYNC_SEEN];
    end

    // Writes decode in the access cycle; the status clear fires at the setup edge,
    // where read data is captured, so an event between capture and clear is never lost
    always_comb
    begin
        wr_set = 1'b0;
        wr_clr = 1'b0;
        wr_force = 1'b0;
        rd_status = 1'b0;
        known = 1'b1;
        if (req.addr == ssimk_pkg::ADDR_ENABLE_SET)
            wr_set = access && req.write;
        else if (req.addr == ssimk_pkg::ADDR_ENABLE_CLEAR)
            wr_clr = access && req.write;
        else if (req.addr == ssimk_pkg::ADDR_EVENT_FORCE)
            wr_force = access && req.write;
        else if (req.addr == ssimk_pkg::ADDR_STATUS)
            rd_status = req.sel && !req.enable && !req.write;
        else if (req.addr != ssimk_pkg::ADDR_MASK_READBACK)
            known = 1'b0;
    end

    // Zero-wait slave; unmapped addresses flag an error
    assign pready = 1'b1;
    assign pslverr = access && !known;

    // Force pulses last one cycle, only for the sticky sources
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            force_q <= ssimk_pkg::FLAGS_RESET;
        else if (wr_force)
            force_q <= req.wdata[N-1:0] & ssimk_pkg::STICKY_SOURCES;
        else
            force_q <= ssimk_pkg::FLAGS_RESET;
    end

    ssimk_mask_reg #(
        .WIDTH(N)
    ) u_mask (
        .pclk(pclk),
        .presetn(presetn),
        .set_stb(wr_set),
        .clr_stb(wr_clr),
        .wbits(req.wdata[N-1:0]),
        .mask(mask)
    );

    ssimk_event_flags #(
        .WIDTH(N),
        .STICKY(ssimk_pkg::STICKY_SOURCES)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .src(src),
        .status_read(rd_status),
        .flags(flags)
    );

    // Read mux; upper bits held at zero, write-only registers read zero
    always_comb
    begin
        rword = '0;
        if (req.addr == ssimk_pkg::ADDR_MASK_READBACK)
            rword.bits = mask;
        else if (req.addr == ssimk_pkg::ADDR_STATUS)
            rword.bits = flags;
    end

    // Read data registered in setup so it is stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (req.sel && !req.enable && !req.write)
            prdata_q <= rword;
    end
    assign prdata = prdata_q;

    // Registered level interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(flags & mask);
    end
    assign irq = irq_q;
endmodule : ssimk_top
`default_nettype wire

// *** verilog/ssimk_pkg.sv ***
`default_nettype none
package ssimk_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] ADDR_ENABLE_SET = 12'h044;
    localparam logic [11:0] ADDR_ENABLE_CLEAR = 12'h048;
    localparam logic [11:0] ADDR_MASK_READBACK = 12'h04C;
    localparam logic [11:0] ADDR_STATUS = 12'h040;
    localparam logic [11:0] ADDR_EVENT_FORCE = 12'h050;

    // Source bit positions
    localparam int BIT_TX_HOLDING_FREE = 0;
    localparam int BIT_TX_FULLY_DRAINED = 1;
    localparam int BIT_TX_TRANSFER_COUNT_DONE = 2;
    localparam int BIT_TX_BUFFERS_EXHAUSTED = 3;
    localparam int BIT_RX_WORD_AVAILABLE = 4;
    localparam int BIT_RX_OVERWRITE_ERROR = 5;
    localparam int BIT_RX_TRANSFER_COUNT_DONE = 6;
    localparam int BIT_RX_BUFFERS_FILLED = 7;
    localparam int BIT_COMPARE_ZERO_HIT = 8;
    localparam int BIT_COMPARE_ONE_HIT = 9;
    localparam int BIT_TX_FRAME_SYNC_SEEN = 10;
    localparam int BIT_RX_FRAME_SYNC_SEEN = 11;
    localparam int NUM_SOURCES = 12;

    // Sources whose flag is sticky until a status read
    localparam logic [11:0] STICKY_SOURCES = 12'hF20;
    localparam logic [11:0] MASK_RESET = 12'h000;
    localparam logic [11:0] FLAGS_RESET = 12'h000;

    // Read-data word from one register
    typedef struct packed {
        logic [19:0] reserved;
        logic [11:0] bits;
    } ssimk_word_s;

    // One APB request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ssimk_apb_req_s;
endpackage : ssimk_pkg
`default_nettype wire

// *** verilog/ssimk_mask_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssimk_mask_reg #(
    parameter int WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_stb,
    input wire logic clr_stb,
    input wire logic [WIDTH-1:0] wbits,
    output logic [WIDTH-1:0] mask
);
    logic [WIDTH-1:0] mask_q;

    // Per-bit set/clear; writes of 0 leave a bit alone
    genvar g;
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                mask_q[g] <= 1'b0;
            else if (set_stb && wbits[g])
                mask_q[g] <= 1'b1;
            else if (clr_stb && wbits[g])
                mask_q[g] <= 1'b0;
        end
    end

    assign mask = mask_q;
endmodule : ssimk_mask_reg
`default_nettype wire

// *** verilog/ssimk_event_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssimk_event_flags #(
    parameter int WIDTH = 12,
    parameter logic [11:0] STICKY = ssimk_pkg::STICKY_SOURCES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] src,
    input wire logic status_read,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] sticky_q;

    // Sticky event bits; an event in the read cycle survives the clear
    genvar g;
    for (g = 0; g < WIDTH; g++)
    begin : g_flag
        if (STICKY[g])
        begin : g_sticky
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sticky_q[g] <= 1'b0;
                else if (src[g])
                    sticky_q[g] <= 1'b1;
                else if (status_read)
                    sticky_q[g] <= 1'b0;
            end
            assign flags[g] = sticky_q[g];
        end
        else
        begin : g_level
            // Level sources follow their condition one cycle late
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sticky_q[g] <= 1'b0;
                else
                    sticky_q[g] <= src[g];
            end
            assign flags[g] = sticky_q[g];
        end
    end
endmodule : ssimk_event_flags
`default_nettype wire

// *** dv/ssimk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssimk_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_overwrite_error,
    input wire logic irq
);
    // Bus write lands only at the access edge
    wire acc = psel && penable && pready;
    wire mapped = paddr inside {[12'h040:12'h050]} && paddr[1:0] == 2'b00;
    logic [11:0] msk_q;
    // Mask rebuilt from bus writes alone, so a stuck design register shows up
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            msk_q <= 12'h000;
        else if (acc && pwrite && paddr == ssimk_pkg::ADDR_ENABLE_SET)
            msk_q <= msk_q | pwdata[11:0];
        else if (acc && pwrite && paddr == ssimk_pkg::ADDR_ENABLE_CLEAR)
            msk_q <= msk_q & ~pwdata[11:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_MASK_READ: assert property (acc && !pwrite && paddr == ssimk_pkg::ADDR_MASK_READBACK
        |-> prdata == {20'h0, msk_q}) else $error("mask readback wrong");
    AST_RSVD_ZERO: assert property (acc && !pwrite |-> prdata[31:12] == 20'h0)
        else $error("reserved bits set");
    AST_UNMAP_ZERO: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_SLVERR: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
    AST_CLR_ALL: assert property (acc && pwrite && paddr == ssimk_pkg::ADDR_ENABLE_CLEAR
        && pwdata[11:0] == 12'hFFF |-> ##2 !irq) else $error("irq after full clear");
    AST_NO_MASK: assert property (msk_q == 12'h000 ##1 msk_q == 12'h000 |-> !irq)
        else $error("irq with no mask");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(msk_q) != 12'h000)
        else $error("irq unmasked");
    AST_OVR_STICKY: assert property (rx_overwrite_error && msk_q[5] |-> ##2 irq ##1 irq)
        else $error("overrun not held");
    COV_OVR: cover property (rx_overwrite_error && msk_q[5]);
    COV_UNMAP: cover property (acc && pslverr);
    COV_IRQ: cover property ($fell(irq));
endmodule : ssimk_checker
bind ssimk_top ssimk_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_overwrite_error(rx_overwrite_error), .irq(irq));
`default_nettype wire

// *** dv/test_serial_sync_irq_mask_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_serial_sync_irq_mask_logic;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000, src = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, er;
    int mismatches = 0, checks_done = 0;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    ssimk_top u_ssimk_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_holding_free(src[0]), .tx_fully_drained(src[1]),
        .tx_transfer_count_done(src[2]), .tx_buffers_exhausted(src[3]),
        .rx_word_available(src[4]), .rx_overwrite_error(src[5]),
        .rx_transfer_count_done(src[6]), .rx_buffers_filled(src[7]),
        .compare_zero_hit(src[8]), .compare_one_hit(src[9]),
        .tx_frame_sync_seen(src[10]), .rx_frame_sync_seen(src[11]), .irq(irq));
    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One transfer; an idle edge first keeps back-to-back calls from double-driving
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_unmap();
        apb(1'b0, ssimk_pkg::ADDR_MASK_READBACK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ssimk_pkg::ADDR_MASK_READBACK, 32'hFFFFFFFF);
        apb(1'b1, 12'h3FC, 32'hFFFFFFFF);
        apb(1'b0, 12'h3FC, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, ssimk_pkg::ADDR_MASK_READBACK, 32'h0);
        chk(rd, 32'h0);
    endtask : t_unmap
    // Set the bits one at a time, then clear them one at a time; upper bits written as ones must not stick
    task automatic t_regs();
        logic [11:0] m;
        m = 12'h000;
        for (int k = 0; k < 24; k++)
        begin
            m[k % 12] = k < 12;
            apb(1'b1, k < 12 ? ssimk_pkg::ADDR_ENABLE_SET : ssimk_pkg::ADDR_ENABLE_CLEAR,
                32'hFFFFF000 | (32'h1 << (k % 12)));
            apb(1'b0, ssimk_pkg::ADDR_MASK_READBACK, 32'h0);
            chk(rd, {20'h0, m});
        end
    endtask : t_regs
    // Each source with a neighbour's mask bit only, then with its own
    task automatic t_src();
        for (int i = 0; i < 12; i++)
            for (int m = 0; m < 2; m++)
            begin
                apb(1'b1, ssimk_pkg::ADDR_ENABLE_CLEAR, 32'h00000FFF);
                apb(1'b1, ssimk_pkg::ADDR_ENABLE_SET, 32'h1 << ((i + 1 - m) % 12));
                src[i] <= 1'b1;
                repeat (4) @(posedge pclk);
                chk(32'(irq), 32'(m));
                src[i] <= 1'b0;
                repeat (4) @(posedge pclk);
                chk(32'(irq), 32'(m & ssimk_pkg::STICKY_SOURCES[i]));
                apb(1'b0, ssimk_pkg::ADDR_STATUS, 32'h0);
                chk(32'(rd[i]), 32'(ssimk_pkg::STICKY_SOURCES[i]));
                repeat (3) @(posedge pclk);
                chk(32'(irq), 32'h0);
            end
    endtask : t_src
    // Injected pulses stick until read; a source held through the clear survives it
    task automatic t_force();
        apb(1'b1, ssimk_pkg::ADDR_ENABLE_SET, 32'h00000FFF);
        apb(1'b1, ssimk_pkg::ADDR_EVENT_FORCE, 32'hFFFFFFFF);
        src[9] <= 1'b1;
        apb(1'b0, ssimk_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000F20);
        chk(32'(irq), 32'h1);
        src[9] <= 1'b0;
        apb(1'b0, ssimk_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000200);
        apb(1'b0, ssimk_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000000);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b1, ssimk_pkg::ADDR_ENABLE_CLEAR, 32'h00000FFF);
    endtask : t_force
    // Main sequence after ten reset cycles
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_unmap();
        t_regs();
        t_src();
        t_force();
        report_and_stop();
    end
    // Watchdog well past the expected run of about 670 cycles
    initial
    begin
        #200us;
        mismatches++;
        report_and_stop();
    end
endmodule : test_serial_sync_irq_mask_logic
`default_nettype wire
